// [core/cprs_pkg.sv]
// How it works
// - accumulator A is 16 bits with data length flag clear, 8 bits when set
// - 8-bit accumulator writes touch only the low byte, upper byte kept
// - accumulator B behaves like A under the same data length flag
// - index X is 16 bits with index flag clear, 8 bits when set
// - 8-bit index use changes only the low byte of X
// - X-indexed modes add X into the effective address
// - block move source is third instruction byte over X
// - index Y is 16 bits like X, width set by the index flag
// - block move destination is second instruction byte over Y
// - stack pointer is 16 bits and always addresses bank zero
// - interrupt pushes bank, PC high, PC low, status high, status low
// - after interrupt push the stack pointer is five lower
// - returns pop in reverse order and restore the stack pointer
// - calls push like interrupts without status, bank optional
// - stack pointer is not set by reset
// - PC holds low 16 fetch bits and reads FFFE during reset
// - after reset the PC loads the vector at FFFE and FFFF
// - program bank follows PC carry and borrow, resets to zero
// - data bank gives upper address byte, loaded by instruction, resets zero
// - direct page is 256 bytes from its base, may cross into bank one
// - direct page base low byte zero gives the fastest address
// - direct page base clears to zero on reset
// - data length flag is status bit 5, clear at reset
// - index width flag is status bit 4, clear at reset
package cprs_pkg;
    localparam int          DATA_W      = 16;
    localparam int          BYTE_W      = 8;
    localparam int          ADDR_W      = 24;
    localparam int          STATUS_W    = 11;
    localparam int          FLAG_M_BIT  = 5;
    localparam int          FLAG_X_BIT  = 4;
    localparam int          IPL_LSB     = 8;
    localparam logic [15:0] PC_RESET    = 16'hfffe;
    localparam logic [15:0] VEC_LO_ADDR = 16'hfffe;
    localparam logic [15:0] VEC_HI_ADDR = 16'hffff;
    localparam logic [7:0]  BANK_RESET  = 8'h00;
    localparam logic [7:0]  STACK_BANK  = 8'h00;
    localparam logic [15:0] DPB_RESET   = 16'h0000;
    localparam logic [10:0] STAT_RESET  = 11'h004;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam logic [2:0]  FRAME_LEN   = 3'h5;
    localparam logic [2:0]  CALL_LEN    = 3'h3;
    localparam logic [2:0]  SHORT_START = 3'h1;

    typedef enum logic [3:0] {
        CPRS_SEL_A, CPRS_SEL_B, CPRS_SEL_X, CPRS_SEL_Y, CPRS_SEL_S,
        CPRS_SEL_DPB, CPRS_SEL_DBANK, CPRS_SEL_STAT, CPRS_SEL_PC, CPRS_SEL_PBANK
    } cprs_sel_t;

    typedef enum logic [2:0] {
        CPRS_STK_IRQ, CPRS_STK_CALL_LONG, CPRS_STK_CALL_SHORT,
        CPRS_STK_RET_IRQ, CPRS_STK_RET_LONG, CPRS_STK_RET_SHORT
    } cprs_stk_t;

    typedef enum logic [2:0] {
        CPRS_AM_ABS, CPRS_AM_ABS_X, CPRS_AM_ABS_Y, CPRS_AM_DIR,
        CPRS_AM_DIR_X, CPRS_AM_BLK_SRC, CPRS_AM_BLK_DST, CPRS_AM_STACK
    } cprs_am_t;

    // frame slot order: bank, pc high, pc low, status high, status low
    function automatic logic [7:0] cprs_frame_byte(input logic [2:0]  slot,
                                                   input logic [7:0]  bank,
                                                   input logic [15:0] pc,
                                                   input logic [10:0] stat);
        case (slot)
            3'h0:    cprs_frame_byte = bank;
            3'h1:    cprs_frame_byte = pc[15:8];
            3'h2:    cprs_frame_byte = pc[7:0];
            3'h3:    cprs_frame_byte = {5'h00, stat[10:8]};
            default: cprs_frame_byte = stat[7:0];
        endcase
    endfunction : cprs_frame_byte
endpackage : cprs_pkg

// [core/cprs_width_merge.sv]
`timescale 1ns/1ps
// byte-preserving write of a switchable-width register
module cprs_width_merge
    import cprs_pkg::*;
#(
    parameter int W = DATA_W
) (
    input  wire logic         narrow,
    input  wire logic [W-1:0] old_val,
    input  wire logic [W-1:0] wr_val,
    output logic      [W-1:0] merged
);
    always_comb begin
        if (narrow) begin
            merged = {old_val[W-1:BYTE_W], wr_val[BYTE_W-1:0]};
        end else begin
            merged = wr_val;
        end
    end
endmodule : cprs_width_merge

// [core/cprs_addr_gen.sv]
`timescale 1ns/1ps
// combinational effective address former
module cprs_addr_gen
    import cprs_pkg::*;
(
    input  wire cprs_am_t    mode,
    input  wire logic [15:0] operand,
    input  wire logic [7:0]  instr_bank,
    input  wire logic [15:0] idx_x,
    input  wire logic [15:0] idx_y,
    input  wire logic [15:0] sp,
    input  wire logic [7:0]  dbank,
    input  wire logic [15:0] dpb,
    output logic      [23:0] addr,
    output logic             slow
);
    logic [16:0] dp_sum;
    logic [23:0] abs_base;

    always_comb begin
        abs_base = {dbank, operand};
        dp_sum   = {1'b0, dpb} + {9'h000, operand[7:0]};
        slow     = (dpb[7:0] != BYTE_ZERO);
        case (mode)
            CPRS_AM_ABS:     addr = abs_base;
            CPRS_AM_ABS_X:   addr = abs_base + {8'h00, idx_x};
            CPRS_AM_ABS_Y:   addr = abs_base + {8'h00, idx_y};
            CPRS_AM_DIR:     addr = {7'h00, dp_sum};
            CPRS_AM_DIR_X:   addr = {7'h00, dp_sum} + {8'h00, idx_x};
            CPRS_AM_BLK_SRC: addr = {instr_bank, idx_x};
            CPRS_AM_BLK_DST: addr = {instr_bank, idx_y};
            default:         addr = {STACK_BANK, sp};
        endcase
        if (mode != CPRS_AM_DIR && mode != CPRS_AM_DIR_X) begin
            slow = 1'b0;
        end
    end
endmodule : cprs_addr_gen

// [core/cprs_regs.sv]
`timescale 1ns/1ps
// programmer-visible register set with stack sequencer and reset vector fetch
module cprs_regs
    import cprs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // register write port, taken only while idle
    input  wire logic        wr_en,
    input  wire cprs_sel_t   wr_sel,
    input  wire logic [15:0] wr_data,
    // program counter stepping
    input  wire logic        pc_step_en,
    input  wire logic        pc_step_sub,
    input  wire logic [15:0] pc_step,
    // stack sequences
    input  wire logic        stk_start,
    input  wire cprs_stk_t   stk_kind,
    // address generation
    input  wire cprs_am_t    am_mode,
    input  wire logic [15:0] am_operand,
    input  wire logic [7:0]  am_instr_bank,
    // byte memory port
    output logic             mem_req,
    output logic             mem_we,
    output logic      [23:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic        mem_ack,
    // register contents
    output logic      [15:0] acc_a,
    output logic      [15:0] acc_b,
    output logic      [15:0] idx_x,
    output logic      [15:0] idx_y,
    output logic      [15:0] stack_ptr,
    output logic      [15:0] program_counter,
    output logic      [7:0]  program_bank,
    output logic      [7:0]  data_bank,
    output logic      [15:0] direct_page_base,
    output logic      [10:0] processor_status,
    output logic             data_narrow,
    output logic             index_narrow,
    output logic      [23:0] fetch_addr,
    output logic      [23:0] eff_addr,
    output logic             dp_slow,
    output logic             busy
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        CPRS_ST_VEC_LO, CPRS_ST_VEC_HI, CPRS_ST_IDLE, CPRS_ST_PUSH, CPRS_ST_POP
    } cprs_st_t;

    typedef struct packed {
        logic [3:0][15:0] gpr;
        logic [15:0]      sp;
        logic [15:0]      pc;
        logic [7:0]       pbank;
        logic [7:0]       dbank;
        logic [15:0]      dpb;
        logic [10:0]      stat;
        cprs_st_t         st;
        logic [2:0]       slot;
        logic [2:0]       last;
        logic [23:0]      ea;
        logic             slow;
    } cprs_state_t;

    cprs_state_t r;
    cprs_state_t next_r;

    logic             flag_m;
    logic             flag_x;
    logic [3:0][15:0] merged;
    logic [3:0]       narrow_vec;
    logic [23:0]      ag_addr;
    logic             ag_slow;
    logic [16:0]      pc_sum;
    logic [7:0]       push_byte;

    assign flag_m = r.stat[FLAG_M_BIT];
    assign flag_x = r.stat[FLAG_X_BIT];

    // ************************************************************
    // width-switched writes of A, B, X, Y
    // ************************************************************
    // slots 0,1 follow the data length flag, slots 2,3 the index flag
    assign narrow_vec = {flag_x, flag_x, flag_m, flag_m};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_gpr
            cprs_width_merge #(
                .W       (DATA_W)
            ) u_merge (
                .narrow  (narrow_vec[gi]),
                .old_val (r.gpr[gi]),
                .wr_val  (wr_data),
                .merged  (merged[gi])
            );
        end
    endgenerate

    // ************************************************************
    // address generation
    // ************************************************************
    // index values used in addressing honour the current index width
    cprs_addr_gen u_addr (
        .mode       (am_mode),
        .operand    (am_operand),
        .instr_bank (am_instr_bank),
        .idx_x      (flag_x ? {8'h00, r.gpr[2][7:0]} : r.gpr[2]),
        .idx_y      (flag_x ? {8'h00, r.gpr[3][7:0]} : r.gpr[3]),
        .sp         (r.sp),
        .dbank      (r.dbank),
        .dpb        (r.dpb),
        .addr       (ag_addr),
        .slow       (ag_slow)
    );

    assign push_byte = cprs_frame_byte(r.slot, r.pbank, r.pc, r.stat);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_r      = r;
        pc_sum      = 17'h00000;
        next_r.ea   = ag_addr;
        next_r.slow = ag_slow;

        case (r.st)
            // reset vector fetch: low byte then high byte
            CPRS_ST_VEC_LO: begin
                if (mem_ack) begin
                    next_r.pc[7:0] = mem_rdata;
                    next_r.st      = CPRS_ST_VEC_HI;
                end
            end
            CPRS_ST_VEC_HI: begin
                if (mem_ack) begin
                    next_r.pc[15:8] = mem_rdata;
                    next_r.st       = CPRS_ST_IDLE;
                end
            end
            CPRS_ST_IDLE: begin
                if (stk_start) begin
                    case (stk_kind)
                        CPRS_STK_IRQ: begin
                            next_r.slot = 3'h0;
                            next_r.last = FRAME_LEN - 3'h1;
                            next_r.st   = CPRS_ST_PUSH;
                        end
                        CPRS_STK_CALL_LONG: begin
                            next_r.slot = 3'h0;
                            next_r.last = CALL_LEN - 3'h1;
                            next_r.st   = CPRS_ST_PUSH;
                        end
                        CPRS_STK_CALL_SHORT: begin
                            next_r.slot = SHORT_START;
                            next_r.last = CALL_LEN - 3'h1;
                            next_r.st   = CPRS_ST_PUSH;
                        end
                        CPRS_STK_RET_IRQ: begin
                            next_r.slot = FRAME_LEN - 3'h1;
                            next_r.last = 3'h0;
                            next_r.st   = CPRS_ST_POP;
                        end
                        CPRS_STK_RET_LONG: begin
                            next_r.slot = CALL_LEN - 3'h1;
                            next_r.last = 3'h0;
                            next_r.st   = CPRS_ST_POP;
                        end
                        default: begin
                            next_r.slot = CALL_LEN - 3'h1;
                            next_r.last = SHORT_START;
                            next_r.st   = CPRS_ST_POP;
                        end
                    endcase
                end else if (wr_en) begin
                    case (wr_sel)
                        CPRS_SEL_A:   next_r.gpr[0] = merged[0];
                        CPRS_SEL_B:   next_r.gpr[1] = merged[1];
                        CPRS_SEL_X:   next_r.gpr[2] = merged[2];
                        CPRS_SEL_Y:   next_r.gpr[3] = merged[3];
                        CPRS_SEL_S:   next_r.sp     = wr_data;
                        CPRS_SEL_DPB:   next_r.dpb   = wr_data;
                        CPRS_SEL_DBANK: next_r.dbank = wr_data[7:0];
                        CPRS_SEL_STAT:  next_r.stat  = wr_data[10:0];
                        CPRS_SEL_PC:    next_r.pc    = wr_data;
                        CPRS_SEL_PBANK: next_r.pbank = wr_data[7:0];
                        default:        next_r.stat  = r.stat;
                    endcase
                end else if (pc_step_en) begin
                    // bank follows the 17th bit so code runs across banks
                    if (pc_step_sub) begin
                        pc_sum    = {1'b0, r.pc} - {1'b0, pc_step};
                        next_r.pc = pc_sum[15:0];
                        if (pc_sum[16]) begin
                            next_r.pbank = r.pbank - 8'h01;
                        end
                    end else begin
                        pc_sum    = {1'b0, r.pc} + {1'b0, pc_step};
                        next_r.pc = pc_sum[15:0];
                        if (pc_sum[16]) begin
                            next_r.pbank = r.pbank + 8'h01;
                        end
                    end
                end
            end
            // write at S, then step S down one per byte
            CPRS_ST_PUSH: begin
                if (mem_ack) begin
                    next_r.sp = r.sp - 16'h0001;
                    if (r.slot == r.last + (FRAME_LEN - 3'h1 - r.last)
                        && r.slot == FRAME_LEN - 3'h1) begin
                        next_r.st = CPRS_ST_IDLE;
                    end else if (r.last != FRAME_LEN - 3'h1
                                 && r.slot == r.last) begin
                        next_r.st = CPRS_ST_IDLE;
                    end else begin
                        next_r.slot = r.slot + 3'h1;
                    end
                end
            end
            // step S up one, then read there; slots come back reversed
            CPRS_ST_POP: begin
                if (mem_ack) begin
                    next_r.sp = r.sp + 16'h0001;
                    case (r.slot)
                        3'h0:    next_r.pbank      = mem_rdata;
                        3'h1:    next_r.pc[15:8]   = mem_rdata;
                        3'h2:    next_r.pc[7:0]    = mem_rdata;
                        3'h3:    next_r.stat[10:8] = mem_rdata[2:0];
                        default: next_r.stat[7:0]  = mem_rdata;
                    endcase
                    if (r.slot == r.last) begin
                        next_r.st = CPRS_ST_IDLE;
                    end else begin
                        next_r.slot = r.slot - 3'h1;
                    end
                end
            end
            default: next_r.st = CPRS_ST_IDLE;
        endcase

        if (!rstn) begin
            next_r.gpr  = r.gpr;
            next_r.sp   = r.sp;
            next_r.pc   = PC_RESET;
            next_r.pbank = BANK_RESET;
            next_r.dbank = BANK_RESET;
            next_r.dpb   = DPB_RESET;
            next_r.stat  = STAT_RESET;
            next_r.st   = CPRS_ST_VEC_LO;
            next_r.slot = 3'h0;
            next_r.last = 3'h0;
            next_r.ea   = {ADDR_W{1'b0}};
            next_r.slow = 1'b0;
        end
    end

    // ************************************************************
    // register
    // ************************************************************
    // reset acts even with the enable low; the stack pointer stays untouched
    always_ff @(posedge clk) begin
        if (ce || !rstn) begin
            r <= next_r;
        end
    end

    // ************************************************************
    // memory port
    // ************************************************************
    always_comb begin
        mem_req   = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = {STACK_BANK, r.sp};
        mem_wdata = BYTE_ZERO;
        if (rstn) begin
            case (r.st)
                CPRS_ST_VEC_LO: begin
                    mem_req  = 1'b1;
                    mem_addr = {STACK_BANK, VEC_LO_ADDR};
                end
                CPRS_ST_VEC_HI: begin
                    mem_req  = 1'b1;
                    mem_addr = {STACK_BANK, VEC_HI_ADDR};
                end
                CPRS_ST_PUSH: begin
                    mem_req   = 1'b1;
                    mem_we    = 1'b1;
                    mem_addr  = {STACK_BANK, r.sp};
                    mem_wdata = push_byte;
                end
                CPRS_ST_POP: begin
                    mem_req  = 1'b1;
                    mem_addr = {STACK_BANK, r.sp + 16'h0001};
                end
                default: mem_req = 1'b0;
            endcase
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign acc_a            = r.gpr[0];
    assign acc_b            = r.gpr[1];
    assign idx_x            = r.gpr[2];
    assign idx_y            = r.gpr[3];
    assign stack_ptr        = r.sp;
    assign program_counter  = r.pc;
    assign program_bank     = r.pbank;
    assign data_bank        = r.dbank;
    assign direct_page_base = r.dpb;
    assign processor_status = r.stat;
    assign data_narrow      = flag_m;
    assign index_narrow     = flag_x;
    assign fetch_addr       = {r.pbank, r.pc};
    assign eff_addr         = r.ea;
    assign dp_slow          = r.slow;
    assign busy             = (r.st != CPRS_ST_IDLE);
endmodule : cprs_regs

// [tb/cprs_regs_asserts.sv]
`timescale 1ns/1ps
module cprs_regs_chk
    import cprs_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic        wr_en,
    input wire logic        pc_step_en,
    input wire logic        pc_step_sub,
    input wire logic        stk_start,
    input wire cprs_sel_t   wr_sel,
    input wire cprs_stk_t   stk_kind,
    input wire cprs_am_t    am_mode,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] pc_step,
    input wire logic [15:0] acc_a,
    input wire logic [15:0] idx_x,
    input wire logic [15:0] stack_ptr,
    input wire logic [15:0] program_counter,
    input wire logic [15:0] direct_page_base,
    input wire logic [7:0]  am_instr_bank,
    input wire logic [7:0]  mem_wdata,
    input wire logic [7:0]  program_bank,
    input wire logic [7:0]  data_bank,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic        data_narrow,
    input wire logic        index_narrow,
    input wire logic        dp_slow,
    input wire logic        busy,
    input wire logic [23:0] mem_addr,
    input wire logic [23:0] eff_addr,
    input wire logic [10:0] processor_status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [15:0] sp_mark;
    wire go_wr = ce && wr_en && !busy && !stk_start;
    // depth check needs the pointer from the edge that launched the frame
    always_ff @(posedge clk) begin
        if (ce && !busy && stk_start)
            sp_mark <= stack_ptr;
    end
    sequence s_irq_go;
        ce && !busy && stk_start && stk_kind == CPRS_STK_IRQ;
    endsequence
    sequence s_irq_done;
        first_match(busy ##[1:60] $fell(busy));
    endsequence
    a_reset_vals: assert property (disable iff (1'b0) !rstn |=>
        program_counter == 16'hfffe && program_bank == 8'h00 && data_bank == 8'h00
        && direct_page_base == 16'h0000 && processor_status == 11'h004)
        else $error("register reset values wrong");
    a_wide_acc: assert property (go_wr && wr_sel == CPRS_SEL_A && !data_narrow
        |=> acc_a == $past(wr_data)) else $error("wide accumulator write wrong");
    a_narrow_acc: assert property (go_wr && wr_sel == CPRS_SEL_A && data_narrow
        |=> $stable(acc_a[15:8]) && acc_a[7:0] == $past(wr_data[7:0]))
        else $error("narrow accumulator write wrong");
    a_narrow_index: assert property (go_wr && wr_sel == CPRS_SEL_X && index_narrow
        |=> $stable(idx_x[15:8]) && idx_x[7:0] == $past(wr_data[7:0]))
        else $error("narrow index write wrong");
    a_pc_carry: assert property (ce && !busy && !stk_start && !wr_en && pc_step_en
        && !pc_step_sub && ({1'b0, program_counter} + {1'b0, pc_step}) > 17'h0ffff
        |=> program_bank == $past(program_bank) + 8'h01) else $error("bank carry missed");
    a_stack_bank: assert property (mem_req |-> mem_addr[23:16] == 8'h00)
        else $error("memory access outside bank zero");
    a_irq_first: assert property (s_irq_go |=> mem_req && mem_we
        && mem_addr == {8'h00, $past(stack_ptr)} && mem_wdata == $past(program_bank))
        else $error("first interrupt push wrong");
    a_irq_depth: assert property (s_irq_go |=> s_irq_done
        ##0 stack_ptr == sp_mark - 16'h5) else $error("interrupt frame depth wrong");
    // a narrow index only contributes its low byte
    a_blk_src: assert property (ce && am_mode == CPRS_AM_BLK_SRC
        |=> eff_addr == {$past(am_instr_bank), ($past(index_narrow)
        ? {8'h00, $past(idx_x[7:0])} : $past(idx_x))}) else $error("source address wrong");
    a_dp_slow: assert property (ce && am_mode == CPRS_AM_DIR
        |=> dp_slow == ($past(direct_page_base[7:0]) != 8'h00)) else $error("slow flag wrong");
endmodule : cprs_regs_chk
bind cprs_regs cprs_regs_chk u_chk (.*);

// [tb/tb_cpu_programmer_register_set.sv]
`timescale 1ns/1ps
module tb_cpu_programmer_register_set import cprs_pkg::*;;
    logic        clk = 0, rstn = 0, ce = 1, wr_en = 0, pc_step_en = 0, pc_step_sub = 0;
    logic        stk_start = 0, mem_ack = 0, mem_req, mem_we, data_narrow, index_narrow;
    logic        dp_slow, busy;
    logic [15:0] wr_data = 0, pc_step = 0, am_operand = 0, acc_a, acc_b, idx_x, idx_y;
    logic [15:0] stack_ptr, program_counter, direct_page_base;
    logic [7:0]  am_instr_bank = 0, mem_rdata = 0, mem_wdata, program_bank, data_bank;
    logic [23:0] mem_addr, fetch_addr, eff_addr;
    logic [10:0] processor_status;
    cprs_sel_t   wr_sel = CPRS_SEL_A;
    cprs_stk_t   stk_kind = CPRS_STK_IRQ;
    cprs_am_t    am_mode = CPRS_AM_ABS;
    logic [7:0]  ram [0:65535];
    int          bad_count = 0, n_checks = 0, cyc = 0;
    cprs_regs DUT (.*);
    always #2 clk = ~clk;
    // ***************************************
    // memory side: one ack per request, read line scrambled when idle
    // ***************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        mem_ack <= mem_req && !mem_ack;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            mem_rdata <= ram[mem_addr[15:0]];
            if (mem_we)
                ram[mem_addr[15:0]] <= mem_wdata;
        end
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp)
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            bad_count++;
    endtask : chk
    task automatic wr(input cprs_sel_t s, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1;
        wr_sel <= s;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 0;
        #1;
    endtask : wr
    task automatic wait_idle();
        int n = 0;
        #1;
        while (busy !== 1'b0 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n < 60, 1);
    endtask : wait_idle
    task automatic stk(input cprs_stk_t k, input logic [15:0] sp_exp);
        @(posedge clk);
        stk_start <= 1;
        stk_kind <= k;
        @(posedge clk);
        stk_start <= 0;
        wait_idle();
        chk(stack_ptr, sp_exp);
    endtask : stk
    task automatic step(input logic sub, input logic [15:0] amt, input logic [23:0] exp);
        @(posedge clk);
        pc_step_en <= 1;
        pc_step_sub <= sub;
        pc_step <= amt;
        @(posedge clk);
        pc_step_en <= 0;
        #1;
        chk(fetch_addr, exp);
    endtask : step
    task automatic am(input cprs_am_t m, input logic [15:0] op, input logic [23:0] exp);
        @(posedge clk);
        am_mode <= m;
        am_operand <= op;
        am_instr_bank <= 8'h7e;
        @(posedge clk);
        #1;
        chk(eff_addr, exp);
    endtask : am
    task automatic t_reset(input logic [15:0] sp_keep);
        repeat (20) @(posedge clk);
        #1;
        chk({program_counter, program_bank, data_bank}, 32'hfffe_0000);
        chk({direct_page_base, processor_status}, 27'h0000_004);
        chk(stack_ptr, sp_keep);
        @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        wait_idle();
        chk(program_counter, 16'h1234);
    endtask : t_reset
    task automatic t_width();
        cprs_sel_t s [4] = '{CPRS_SEL_A, CPRS_SEL_B, CPRS_SEL_X, CPRS_SEL_Y};
        logic [63:0] v;
        for (int i = 0; i < 4; i++) begin
            wr(CPRS_SEL_STAT, 16'h0000);
            wr(s[i], 16'h1234 + 16'(i));
            v = {idx_y, idx_x, acc_b, acc_a};
            chk(v[16*i +: 16], 16'h1234 + 16'(i));
            wr(CPRS_SEL_STAT, (i < 2) ? 16'h0020 : 16'h0010);
            chk({data_narrow, index_narrow}, (i < 2) ? 2'b10 : 2'b01);
            wr(s[i], 16'hffc0 + 16'(i));
            v = {idx_y, idx_x, acc_b, acc_a};
            chk(v[16*i +: 16], 16'h12c0 + 16'(i));
        end
    endtask : t_width
    task automatic t_pc();
        wr(CPRS_SEL_PBANK, 16'h0012);
        wr(CPRS_SEL_PC, 16'hffff);
        step(0, 16'h0002, 24'h130001);
        step(1, 16'h0003, 24'h12fffe);
        wr(CPRS_SEL_DBANK, 16'h005a);
        chk(data_bank, 8'h5a);
        // a write offered with the enable low must leave the register as it was
        @(posedge clk);
        ce <= 0;
        wr(CPRS_SEL_DBANK, 16'h00a5);
        chk(data_bank, 8'h5a);
        @(posedge clk);
        ce <= 1;
    endtask : t_pc
    task automatic t_stack();
        wr(CPRS_SEL_STAT, 16'h05a5);
        wr(CPRS_SEL_S, 16'h01ff);
        wr(CPRS_SEL_PC, 16'h3456);
        stk(CPRS_STK_IRQ, 16'h01fa);
        chk({ram[16'h1ff], ram[16'h1fe], ram[16'h1fd], ram[16'h1fc], ram[16'h1fb]},
            40'h12345605a5);
        wr(CPRS_SEL_PC, 16'h0000);
        wr(CPRS_SEL_PBANK, 16'h0000);
        wr(CPRS_SEL_STAT, 16'h0000);
        stk(CPRS_STK_RET_IRQ, 16'h01ff);
        chk({program_bank, program_counter, 1'b0, processor_status}, 36'h123456_5a5);
        stk(CPRS_STK_CALL_LONG, 16'h01fc);
        stk(CPRS_STK_CALL_SHORT, 16'h01fa);
        chk({ram[16'h1ff], ram[16'h1fe], ram[16'h1fd], ram[16'h1fc], ram[16'h1fb]},
            40'h1234563456);
        stk(CPRS_STK_RET_SHORT, 16'h01fc);
        stk(CPRS_STK_RET_LONG, 16'h01ff);
    endtask : t_stack
    task automatic t_addr();
        wr(CPRS_SEL_X, 16'h4321);
        wr(CPRS_SEL_Y, 16'h8765);
        wr(CPRS_SEL_DPB, 16'hff80);
        am(CPRS_AM_BLK_SRC, 16'h0000, 24'h7e4321);
        am(CPRS_AM_BLK_DST, 16'h0000, 24'h7e8765);
        am(CPRS_AM_ABS_X, 16'h1000, 24'h5a5321);
        am(CPRS_AM_DIR, 16'h0090, 24'h010010);
        chk(dp_slow, 1'b1);
        wr(CPRS_SEL_DPB, 16'h0200);
        am(CPRS_AM_DIR, 16'h0090, 24'h000290);
        chk(dp_slow, 1'b0);
    endtask : t_addr
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        ram[16'hfffe] = 8'h34;
        ram[16'hffff] = 8'h12;
        t_reset(stack_ptr);
        t_width();
        t_pc();
        t_stack();
        t_addr();
        @(posedge clk);
        rstn <= 0;
        t_reset(16'h01ff);
        report_and_stop();
    end
endmodule : tb_cpu_programmer_register_set
